// ===== gpib_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz clock
// Notes: Definitions only
`ifndef GPIB_DEFINES_SVH
`define GPIB_DEFINES_SVH
`define OFS_BUS_ADDRESS_CONFIG 8'h19
`define OFS_SERIAL_POLL_REPLY 8'h1b
`define OFS_PARALLEL_POLL_REPLY 8'h1d
`define OFS_BUS_DATA_OUT 8'h1f
`define OFS_CTRL_COMMAND 8'h20
`define OFS_CTRL_STATUS 8'h21
`define BIT_DUAL_ADDR 7
`define BIT_NO_LISTEN 6
`define BIT_NO_TALK 5
`define BIT_SRQ 6
`define RST_BYTE 8'h00
`define IFC_MIN_US 100
`define CLK_MHZ 50
`define IFC_CYCLES (`IFC_MIN_US * `CLK_MHZ)
`endif

// ===== gpib_pkg.sv
// Purpose: Types for the bus interface write registers
// Assumes: Nothing
// Notes: Constants live in gpib_defines.svh
package gpib_pkg;
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_ABORT = 3'h1,
      CMD_CLEAR = 3'h2,
      CMD_LOCAL = 3'h3,
      CMD_LOCK = 3'h4,
      CMD_ATN_OFF = 3'h5
   } ctl_cmd_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_IFC = 2'b01,
      ST_SEND = 2'b11,
      ST_DONE = 2'b10
   } ctl_state_t;
   typedef struct packed {
      logic [7:0] dio;
      logic dio_en;
      logic atn;
      logic ifc;
      logic ren;
      logic srq;
   } bus_out_t;
   typedef struct packed {
      logic atn;
      logic [7:0] dio;
      logic ren_only;
   } seq_out_t;
endpackage : gpib_pkg

// ===== gpib_ctl_seq.sv
// Purpose: Controller sequencer: abort timing and one-byte command issue
// Assumes: Inputs synchronous to clk
// Notes: ATN stays as last set between sequences
`include "gpib_defines.svh"
module gpib_ctl_seq #(
   parameter int IFC_CYCLES = `IFC_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire gpib_pkg::ctl_cmd_t cmd,
   input wire logic is_sys_ctl,
   input wire logic is_active,
   output logic busy,
   output logic error,
   output logic ifc,
   output logic ren_set,
   output logic make_active,
   output gpib_pkg::seq_out_t out
);
   typedef struct packed {
      gpib_pkg::ctl_state_t st;
      logic [15:0] cnt;
      logic err;
      logic ifc;
      logic ren;
      logic act;
      gpib_pkg::seq_out_t o;
   } seq_state_t;
   seq_state_t s, next_s;
   always_comb begin
      next_s = s;
      next_s.ren = 1'b0;
      next_s.act = 1'b0;
      case (s.st)
         gpib_pkg::ST_IDLE: begin
            if (start) begin
               next_s.err = 1'b0;
               if (cmd == gpib_pkg::CMD_ABORT && is_sys_ctl) begin
                  next_s.ifc = 1'b1;
                  next_s.cnt = 16'h0000;
                  next_s.st = gpib_pkg::ST_IFC;
               end else if (cmd == gpib_pkg::CMD_ABORT) begin
                  next_s.st = gpib_pkg::ST_IDLE;
               end else if (!is_active) begin
                  next_s.err = 1'b1;
               end else if (cmd == gpib_pkg::CMD_ATN_OFF) begin
                  next_s.o.atn = 1'b0;
               end else if (cmd != gpib_pkg::CMD_NONE) begin
                  next_s.o.atn = 1'b1;
                  case (cmd)
                     gpib_pkg::CMD_CLEAR: next_s.o.dio = 8'h14;
                     gpib_pkg::CMD_LOCAL: next_s.o.dio = 8'h01;
                     default: next_s.o.dio = 8'h11;
                  endcase
                  next_s.st = gpib_pkg::ST_SEND;
               end
            end
         end
         gpib_pkg::ST_IFC: begin
            next_s.cnt = s.cnt + 16'h0001;
            if (s.cnt == 16'(IFC_CYCLES - 1)) begin
               next_s.ifc = 1'b0;
               next_s.ren = 1'b1;
               next_s.act = 1'b1;
               next_s.o.atn = 1'b1;
               next_s.st = gpib_pkg::ST_DONE;
            end
         end
         gpib_pkg::ST_SEND: next_s.st = gpib_pkg::ST_DONE;
         gpib_pkg::ST_DONE: next_s.st = gpib_pkg::ST_IDLE;
         default: next_s.st = gpib_pkg::ST_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) s <= '0;
      else s <= next_s;
   end
   assign busy = (s.st != gpib_pkg::ST_IDLE);
   assign error = s.err;
   assign ifc = s.ifc;
   assign ren_set = s.ren;
   assign make_active = s.act;
   assign out = s.o;
   ifc_len_a: assert property (@(posedge clk) disable iff (rst)
      $rose(s.ifc) |-> s.ifc [*8]) else $error("IFC too short");
   ifc_count_a: assert property (@(posedge clk) disable iff (rst)
      $fell(s.ifc) |-> s.cnt == 16'(IFC_CYCLES)) else $error("IFC count wrong");
   atn_hold_a: assert property (@(posedge clk) disable iff (rst)
      (s.st == gpib_pkg::ST_IDLE && !start) |=> $stable(s.o.atn))
      else $error("ATN changed without command");
   abort_seq_a: assert property (@(posedge clk) disable iff (rst)
      $fell(s.ifc) |-> s.ren && s.o.atn) else $error("Abort order wrong");
   refuse_a: assert property (@(posedge clk) disable iff (rst)
      (s.st == gpib_pkg::ST_IDLE && start && !is_active && cmd != gpib_pkg::CMD_ABORT
       && cmd != gpib_pkg::CMD_NONE) |=> s.err && s.st == gpib_pkg::ST_IDLE)
      else $error("Command not refused");
   abort_c: cover property (@(posedge clk) disable iff (rst) $fell(s.ifc));
   send_c: cover property (@(posedge clk) disable iff (rst) s.st == gpib_pkg::ST_SEND);
endmodule : gpib_ctl_seq

// ===== gpib_write_regs.sv
// Purpose: Write-side register set of a GPIB talker/listener/controller
// Assumes: Avalon-MM slave with waitrequest, byte offsets as word indices
// Notes: Bus pins are split into level outputs; enables active low
//
// What this block does
// - Address bit 7 set selects dual primary addressing.
// - Address bit 6 set disables listener; listen address is ignored.
// - Address bit 5 set disables talker; talk address is ignored.
// - Address bits 4..0 hold own primary address for matching.
// - Serial poll returns bits 7 and 5..0 unchanged as status.
// - Serial poll reply with bit 6 set raises service request while serial poll is not active.
// - Parallel poll drives data lines from parallel poll reply bits.
// - ATN keeps its last set state between controller sequences.
// - Abort as system controller pulses IFC at least 100 us, then REN and ATN; otherwise abort only clears the error flag.
//
// The Avalon-MM register port is this design's own decision.
`include "gpib_defines.svh"
module gpib_write_regs #(
   parameter int IFC_CYCLES = `IFC_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [7:0] bus_cmd_byte,
   input wire logic bus_atn_in,
   input wire logic serial_poll_active,
   input wire logic parallel_poll_active,
   input wire logic is_sys_ctl,
   output logic [7:0] dio_out,
   output logic dio_oe_n,
   output logic atn_out,
   output logic ifc_out,
   output logic ren_out,
   output logic srq_out,
   output logic listen_addressed,
   output logic talk_addressed,
   output logic byte_ready
);
   typedef struct packed {
      logic [7:0] addr_cfg;
      logic [7:0] spoll;
      logic [7:0] ppoll;
      logic [7:0] dout;
      logic active;
      logic ren;
      logic lad;
      logic tad;
      logic nba;
      logic wreq;
      logic oe_n;
      logic start;
      gpib_pkg::ctl_cmd_t cmd;
      logic [31:0] rdata;
      gpib_pkg::bus_out_t bo;
   } regs_state_t;
   regs_state_t s, next_s;
   logic seq_busy;
   logic seq_err;
   logic seq_ifc;
   logic seq_ren;
   logic seq_act;
   gpib_pkg::seq_out_t seq_o;
   logic [4:0] own;
   logic match_listen;
   logic match_talk;
   logic access;
   logic wr_en;
   assign own = s.addr_cfg[4:0];
   // Dual mode ignores the low address bit
   assign match_listen = bus_cmd_byte[6:5] == 2'b01 && (s.addr_cfg[`BIT_DUAL_ADDR]
      ? bus_cmd_byte[4:1] == own[4:1] : bus_cmd_byte[4:0] == own);
   assign match_talk = bus_cmd_byte[6:5] == 2'b10 && (s.addr_cfg[`BIT_DUAL_ADDR]
      ? bus_cmd_byte[4:1] == own[4:1] : bus_cmd_byte[4:0] == own);
   assign access = (avs_read || avs_write) && s.wreq;
   // Writes land at the edge where waitrequest is seen low
   assign wr_en = avs_write && !s.wreq && avs_byteenable[0];

   gpib_ctl_seq #(.IFC_CYCLES(IFC_CYCLES)) u_seq (
      .clk(clk),
      .rst(rst),
      .start(s.start),
      .cmd(s.cmd),
      .is_sys_ctl(is_sys_ctl),
      .is_active(s.active),
      .busy(seq_busy),
      .error(seq_err),
      .ifc(seq_ifc),
      .ren_set(seq_ren),
      .make_active(seq_act),
      .out(seq_o)
   );

   // ============================================================
   // Register file and bus side
   always_comb begin
      next_s = s;
      next_s.wreq = !access;
      next_s.start = 1'b0;
      next_s.rdata = 32'h0000_0000;
      if (avs_read && s.wreq) begin
         case (avs_address)
            `OFS_CTRL_STATUS: next_s.rdata = {24'h000000, 2'b00, s.nba, s.tad, s.lad,
               seq_err, seq_busy, s.active};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_en) begin
         case (avs_address)
            `OFS_BUS_ADDRESS_CONFIG: next_s.addr_cfg = avs_writedata[7:0];
            `OFS_SERIAL_POLL_REPLY: next_s.spoll = avs_writedata[7:0];
            `OFS_PARALLEL_POLL_REPLY: next_s.ppoll = avs_writedata[7:0];
            `OFS_BUS_DATA_OUT: begin
               next_s.dout = avs_writedata[7:0];
               next_s.nba = 1'b1;
            end
            `OFS_CTRL_COMMAND: begin
               if (!seq_busy) begin
                  next_s.start = 1'b1;
                  next_s.cmd = gpib_pkg::ctl_cmd_t'(avs_writedata[2:0]);
               end
            end
            default: next_s.start = 1'b0;
         endcase
      end
      // ============================================================
      // Bus addressing from received commands
      if (bus_atn_in) begin
         if (match_listen && !s.addr_cfg[`BIT_NO_LISTEN]) next_s.lad = 1'b1;
         else if (bus_cmd_byte == 8'h3f) next_s.lad = 1'b0;
         if (match_talk && !s.addr_cfg[`BIT_NO_TALK]) next_s.tad = 1'b1;
         else if (bus_cmd_byte[6:5] == 2'b10 || bus_cmd_byte == 8'h5f) next_s.tad = 1'b0;
      end
      if (s.addr_cfg[`BIT_NO_LISTEN]) next_s.lad = 1'b0;
      if (s.addr_cfg[`BIT_NO_TALK]) next_s.tad = 1'b0;
      if (seq_act) next_s.active = 1'b1;
      if (seq_ren) next_s.ren = 1'b1;
      // ============================================================
      // Pin drive
      next_s.bo.srq = s.spoll[`BIT_SRQ] && !serial_poll_active;
      next_s.bo.ifc = seq_ifc;
      next_s.bo.ren = s.ren;
      next_s.bo.atn = s.active ? seq_o.atn : 1'b0;
      next_s.bo.dio_en = 1'b0;
      next_s.bo.dio = 8'h00;
      if (parallel_poll_active) begin
         next_s.bo.dio = s.ppoll;
         next_s.bo.dio_en = 1'b1;
      end else if (seq_busy && s.active && seq_o.atn) begin
         next_s.bo.dio = seq_o.dio;
         next_s.bo.dio_en = 1'b1;
      end else if (serial_poll_active && s.tad) begin
         next_s.bo.dio = {s.spoll[7], s.spoll[6], s.spoll[5:0]};
         next_s.bo.dio_en = 1'b1;
      end else if (s.tad && s.nba) begin
         next_s.bo.dio = s.dout;
         next_s.bo.dio_en = 1'b1;
      end
      next_s.oe_n = !next_s.bo.dio_en;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
         s.wreq <= 1'b1;
         s.oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata = s.rdata;
   assign avs_waitrequest = s.wreq;
   assign dio_out = s.bo.dio;
   assign dio_oe_n = s.oe_n;
   assign atn_out = s.bo.atn;
   assign ifc_out = s.bo.ifc;
   assign ren_out = s.bo.ren;
   assign srq_out = s.bo.srq;
   assign listen_addressed = s.lad;
   assign talk_addressed = s.tad;
   assign byte_ready = s.nba;

   // ============================================================
   // Checks
   srq_follow_a: assert property (@(posedge clk) disable iff (rst)
      (s.spoll[6] && !serial_poll_active) |=> srq_out) else $error("SRQ missing");
   ppoll_drive_a: assert property (@(posedge clk) disable iff (rst)
      parallel_poll_active |=> !dio_oe_n && dio_out == $past(s.ppoll))
      else $error("Parallel poll data wrong");
   no_listen_a: assert property (@(posedge clk) disable iff (rst)
      s.addr_cfg[6] |=> !listen_addressed) else $error("Listener not disabled");
   no_talk_a: assert property (@(posedge clk) disable iff (rst)
      s.addr_cfg[5] |=> !talk_addressed) else $error("Talker not disabled");
   addr_match_a: assert property (@(posedge clk) disable iff (rst)
      (bus_atn_in && !s.addr_cfg[7] && !s.addr_cfg[6] && bus_cmd_byte == {3'b001, own})
      |=> listen_addressed) else $error("Own address not matched");
   dual_match_a: assert property (@(posedge clk) disable iff (rst)
      (bus_atn_in && s.addr_cfg[7] && !s.addr_cfg[6] && bus_cmd_byte == {3'b001, own ^ 5'h01})
      |=> listen_addressed) else $error("Dual address not matched");
   dout_drive_a: assert property (@(posedge clk) disable iff (rst)
      (s.tad && s.nba && !parallel_poll_active && !serial_poll_active && !seq_busy)
      |=> dio_out == $past(s.dout)) else $error("Data out not driven");
   spoll_a: assert property (@(posedge clk) disable iff (rst)
      (serial_poll_active && s.tad && !parallel_poll_active && !seq_busy)
      |=> dio_out == $past(s.spoll)) else $error("Serial poll byte wrong");
   cmd_drive_a: assert property (@(posedge clk) disable iff (rst)
      (seq_busy && s.active && seq_o.atn && !parallel_poll_active)
      |=> !dio_oe_n && atn_out) else $error("Command byte not driven with ATN");
   wait_a: assert property (@(posedge clk) disable iff (rst)
      (avs_write && avs_waitrequest) |=> !avs_waitrequest) else $error("No answer");
   ppoll_c: cover property (@(posedge clk) disable iff (rst) parallel_poll_active);
   srq_c: cover property (@(posedge clk) disable iff (rst) $rose(srq_out));
   talk_c: cover property (@(posedge clk) disable iff (rst) $rose(talk_addressed));
endmodule : gpib_write_regs

// ===== gpib_bus_partner.sv
// Purpose: Far-side bus controller that sends commands and runs polls
// Assumes: Driven from the bench through its tasks
// Notes: Released data lines show the inverse of the last byte
module gpib_bus_partner (
   input wire logic clk,
   output logic [7:0] cmd_byte,
   output logic atn,
   output logic spoll,
   output logic ppoll
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_byte = 8'h00;
      atn = 1'b0;
      spoll = 1'b0;
      ppoll = 1'b0;
   end
   task automatic send_cmd(input logic [7:0] b);
      @(posedge clk);
      atn <= 1'b1;
      cmd_byte <= b;
      repeat (2) @(posedge clk);
      atn <= 1'b0;
      cmd_byte <= ~b;
   endtask : send_cmd
   task automatic set_poll(input logic s, input logic p);
      @(posedge clk);
      spoll <= s;
      ppoll <= p;
   endtask : set_poll
endmodule : gpib_bus_partner

// ===== gpib_write_regs_tb_top.sv
// Purpose: Self-checking bench for the bus interface write registers
// Assumes: One access at a time on the register bus
// Notes: Short abort count for simulation
module gpib_write_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IFC_P = 10;
   logic clk, rst, avs_read, avs_write, avs_waitrequest, is_sys_ctl;
   logic [7:0] avs_address, cmd_byte, dio_out;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic atn, spoll, ppoll, dio_oe_n, atn_out, ifc_out, ren_out, srq_out;
   logic listen_addressed, talk_addressed, byte_ready;
   int mismatches, comparisons, cyc, ifc_cnt;
   gpib_write_regs #(.IFC_CYCLES(IFC_P)) DUT (.clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .bus_cmd_byte(cmd_byte), .bus_atn_in(atn), .serial_poll_active(spoll),
      .parallel_poll_active(ppoll), .is_sys_ctl(is_sys_ctl), .dio_out(dio_out),
      .dio_oe_n(dio_oe_n), .atn_out(atn_out), .ifc_out(ifc_out), .ren_out(ren_out),
      .srq_out(srq_out), .listen_addressed(listen_addressed),
      .talk_addressed(talk_addressed), .byte_ready(byte_ready));
   gpib_bus_partner P (.clk(clk), .cmd_byte(cmd_byte), .atn(atn), .spoll(spoll),
      .ppoll(ppoll));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (ifc_out === 1'b1) ifc_cnt++;
      if (cyc == 20000) begin
         mismatches++;
         end_of_test();
      end
   end
   // ==========================================
   // Bus access and compare helpers
   task automatic av_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= 4'h1;
      avs_write <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : av_write
   task automatic av_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask : av_read
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic do_reset();
      rst <= 1'b1;
      is_sys_ctl <= 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset
   task automatic settle();
      repeat (3) @(posedge clk);
   endtask : settle
   task automatic wait_idle();
      logic [31:0] d;
      do av_read(8'h21, d); while (d[1] !== 1'b0);
   endtask : wait_idle
   // ==========================================
   // Scenarios
   task automatic t_addr(input logic [7:0] cfg, input logic [7:0] c, input logic l,
         input logic t);
      do_reset();
      av_write(8'h19, cfg);
      P.send_cmd(c);
      settle();
      chk(listen_addressed, l);
      chk(talk_addressed, t);
   endtask : t_addr
   task automatic t_spoll();
      do_reset();
      av_write(8'h1b, 8'h00);
      av_write(8'h1b, 8'h40);
      settle();
      chk(srq_out, 1'b1);
      av_write(8'h1b, 8'ha5);
      settle();
      chk(srq_out, 1'b0);
      av_write(8'h19, 8'h05);
      P.send_cmd(8'h45);
      P.set_poll(1'b1, 1'b0);
      settle();
      chk({dio_out[7], dio_out[5:0]}, 7'h65);
      P.set_poll(1'b0, 1'b0);
   endtask : t_spoll
   task automatic t_ppoll();
      do_reset();
      av_write(8'h1d, 8'ha5);
      P.set_poll(1'b0, 1'b1);
      settle();
      chk(dio_out, 8'ha5);
      chk(dio_oe_n, 1'b0);
      P.set_poll(1'b0, 1'b0);
      av_write(8'h1d, 8'h00);
      P.set_poll(1'b0, 1'b1);
      settle();
      chk(dio_out, 8'h00);
      P.set_poll(1'b0, 1'b0);
   endtask : t_ppoll
   task automatic t_dout();
      do_reset();
      av_write(8'h19, 8'h05);
      P.send_cmd(8'h45);
      av_write(8'h1f, 8'h3c);
      settle();
      chk(dio_out, 8'h3c);
      chk(byte_ready, 1'b1);
   endtask : t_dout
   task automatic t_ctl();
      logic [31:0] d;
      do_reset();
      av_read(8'h00, d);
      chk(d, 32'h00000000);
      av_write(8'h20, 8'h02);
      settle();
      av_read(8'h21, d);
      chk(d[2], 1'b1);
      chk(atn_out, 1'b0);
      ifc_cnt = 0;
      av_write(8'h20, 8'h01);
      settle();
      chk(ifc_cnt, 32'h00000000);
      is_sys_ctl <= 1'b1;
      ifc_cnt = 0;
      av_write(8'h20, 8'h01);
      wait_idle();
      chk(ifc_cnt >= IFC_P, 1'b1);
      chk({ren_out, atn_out, ifc_out}, 3'h6);
      av_read(8'h21, d);
      chk(d[0], 1'b1);
      av_write(8'h20, 8'h02);
      wait_idle();
      chk(atn_out, 1'b1);
      av_write(8'h20, 8'h05);
      wait_idle();
      chk(atn_out, 1'b0);
      av_write(8'h20, 8'h04);
      wait_idle();
      chk(atn_out, 1'b1);
      av_write(8'h20, 8'h03);
      wait_idle();
      chk(atn_out, 1'b1);
   endtask : t_ctl
   task automatic end_of_test();
      if (mismatches == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   initial begin
      rst = 1'b1;
      is_sys_ctl = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      t_addr(8'h05, 8'h25, 1'b1, 1'b0);
      t_addr(8'h05, 8'h26, 1'b0, 1'b0);
      t_addr(8'h05, 8'h45, 1'b0, 1'b1);
      t_addr(8'h45, 8'h25, 1'b0, 1'b0);
      t_addr(8'h25, 8'h45, 1'b0, 1'b0);
      t_addr(8'h85, 8'h24, 1'b1, 1'b0);
      t_addr(8'h04, 8'h25, 1'b0, 1'b0);
      t_spoll();
      t_ppoll();
      t_dout();
      t_ctl();
      end_of_test();
   end
endmodule : gpib_write_regs_tb_top
